// *** hw/scps_pkg.sv ***
package scps_pkg;
    // =====================================================
    // Register map (offsets chosen locally)
    localparam logic [1:0] SCPS_OFS_TRIM   = 2'h0;   // Oscillator trim
    localparam logic [1:0] SCPS_OFS_DIVCTL = 2'h1;   // Divider control
    localparam logic [1:0] SCPS_OFS_STAT   = 2'h2;   // Start-up status
    // =====================================================
    // Field positions
    localparam int SCPS_PCE_BIT   = 7;               // Change enable bit
    localparam int SCPS_RANGE_BIT = 7;               // Trim range bit
    // =====================================================
    // Codes
    localparam logic [3:0] SCPS_SRC_LP128 = 4'h3;    // Low-power 128 kHz source
    localparam logic [3:0] SCPS_SRC_EXT   = 4'h0;    // External clock input
    localparam logic [3:0] SCPS_DIV_RST8  = 4'h3;    // Divide by 8 reset code
    localparam logic [3:0] SCPS_DIV_RST1  = 4'h0;    // Divide by 1 reset code
    localparam logic [3:0] SCPS_DIV_MAX   = 4'h8;    // Last legal code (/256)
    localparam logic [1:0] SCPS_SUT_RSVD  = 2'h3;    // Reserved start-up code
    localparam logic [2:0] SCPS_PCE_WIN   = 3'h4;    // Change window in cycles
    // =====================================================
    // Timing
    localparam int SCPS_CLK_KHZ      = 10000;        // sys_clk rate
    localparam int SCPS_WAKE_CK      = 6;            // Wake delay cycles
    localparam int SCPS_BASE_CK      = 14;           // Base reset delay cycles
    localparam int SCPS_LP_SHORT_US  = 4000;         // 4 ms
    localparam int SCPS_LP_LONG_US   = 64000;        // 64 ms
    localparam int SCPS_EXT_SHORT_US = 4100;         // 4.1 ms
    localparam int SCPS_EXT_LONG_US  = 65000;        // 65 ms
    localparam int SCPS_LP_SHORT_CK  = SCPS_LP_SHORT_US * SCPS_CLK_KHZ / 1000;
    localparam int SCPS_LP_LONG_CK   = SCPS_LP_LONG_US * SCPS_CLK_KHZ / 1000;
    localparam int SCPS_EXT_SHORT_CK = SCPS_EXT_SHORT_US * SCPS_CLK_KHZ / 1000;
    localparam int SCPS_EXT_LONG_CK  = SCPS_EXT_LONG_US * SCPS_CLK_KHZ / 1000;
    // =====================================================
    // Start-up states
    typedef enum logic [1:0] {
        SCPS_ST_HOLD = 2'b00,    // Counting reset delay
        SCPS_ST_RUN  = 2'b01,    // Clock released
        SCPS_ST_BAD  = 2'b11     // Reserved fuse code
    } scps_state_e;
endpackage

// *** hw/scps_clock_ctrl.sv ***
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// R1: Fuse code 0011 selects 128 kHz oscillator
// R2: 128k start-up delays per startup fuses
// R3: Fuse code 0000 selects external clock input
// R4: External clock start-up delays per fuses
// R5: External clock steps under 2% only
// R6: Clock output fuse drives pin, even in reset
// R7: Output pin carries prescaled clock, any source
// R8: Software enables external timer clock first
// R9: Prescaler divides all synchronous domains
// R10: Divider changes are glitch free
// R11: New rate active after two edges; here it takes effect only at the next period boundary of the old rate
// R12: Change enable set only by lone write
// R13: Software writes divider within four cycles
// R14: Change enable clears after four cycles
// R15: Software masks interrupts during change
// R16: Codes 0 to 8 divide 1 to 256
// R17: Reset code follows divide-by-eight fuse
// R18: Any code writable regardless of fuse
// R19: Trim loads factory value at reset
// R20: Trim top bit selects range
// R21: Low trim bits tune within range
// R22: Software keeps trim below 8.8 MHz
module scps_clock_ctrl
    import scps_pkg::*;
#(
    parameter int         LP_SHORT_CK  = SCPS_LP_SHORT_CK,   // 4 ms delay
    parameter int         LP_LONG_CK   = SCPS_LP_LONG_CK,    // 64 ms delay
    parameter int         EXT_SHORT_CK = SCPS_EXT_SHORT_CK,  // 4.1 ms delay
    parameter int         EXT_LONG_CK  = SCPS_EXT_LONG_CK,   // 65 ms delay
    parameter logic [7:0] FACTORY_TRIM = 8'h80               // Arbitrary factory value
) (
    // Clock and reset
    input  wire  logic       sys_clk,
    input  wire  logic       resetn,
    // Fuses
    input  wire  logic [3:0] clock_source_select_fuses,
    input  wire  logic [1:0] startup_time_fuses,
    input  wire  logic       clock_output_fuse,
    input  wire  logic       divide_by_eight_fuse,
    // Clock sources
    input  wire  logic       lp_osc_clk,
    input  wire  logic       rc_osc_clk,
    input  wire  logic       external_clock_input_pin,
    // Register port
    input  wire  logic [1:0] reg_addr,
    input  wire  logic [7:0] reg_wdata,
    input  wire  logic       reg_wr,
    input  wire  logic       reg_rd,
    output logic       [7:0] reg_rdata,
    // Clock outputs
    output logic             sys_clk_en,
    output logic             clock_output_pin,
    output logic             clock_output_pin_oe,
    output logic             core_ready,
    output logic       [6:0] trim_tune_bits,
    output logic             trim_range_bit,
    output logic             src_is_lp,
    output logic             src_is_ext
);
    // =====================================================
    // Elaboration checks
    // A zero count would let the core run before its clock settles
    if (LP_SHORT_CK < 1 || LP_LONG_CK < 1) begin : g_bad_lp
        $error("low-power delay counts must be positive");
    end
    // Same limit for the external source figures
    if (EXT_SHORT_CK < 1 || EXT_LONG_CK < 1) begin : g_bad_ext
        $error("external delay counts must be positive");
    end

    // =====================================================
    // Source select
    // Source mux itself lives in the clock tree; here only the select
    // Codes other than these two keep the low-power delay figures.
    // The external pin must not step its rate by more than a few
    // percent per cycle; larger steps belong inside a reset.
    // Nothing here can check that: the pin is not clocked by us.
    assign src_is_lp  = (clock_source_select_fuses == SCPS_SRC_LP128);  // R1
    assign src_is_ext = (clock_source_select_fuses == SCPS_SRC_EXT);    // R3

    // =====================================================
    // Start-up delay
    // Only the delay after reset is kept; this block has no sleep
    // state, so the short wake delay never applies here.
    // Trade-off: one wide counter instead of a prescaled one, which
    // costs flops but keeps every fuse figure exact to the cycle.
    scps_state_e st_r;                 // Start-up state
    logic [31:0] dly_cnt_r;            // Delay up counter
    logic [31:0] dly_load;             // Selected delay

    // Delay table by source and fuse code
    // Reserved code keeps the base figure; the state machine parks anyway
    always_comb begin
        dly_load = 32'(SCPS_BASE_CK);
        unique case (startup_time_fuses)
            2'h1: dly_load = 32'(SCPS_BASE_CK + (src_is_ext ? EXT_SHORT_CK : LP_SHORT_CK)); // R2 R4
            2'h2: dly_load = 32'(SCPS_BASE_CK + (src_is_ext ? EXT_LONG_CK : LP_LONG_CK));   // R2 R4
            default: dly_load = 32'(SCPS_BASE_CK);   // Code 00 and reserved 11
        endcase
    end

    // Hold the core until the delay has run out
    // The reserved code parks the machine so software can read why
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_r      <= SCPS_ST_HOLD;
            dly_cnt_r <= 32'h0;
        end else begin
            unique case (st_r)
                SCPS_ST_HOLD: begin
                    if (startup_time_fuses == SCPS_SUT_RSVD) begin
                        st_r <= SCPS_ST_BAD;          // Reserved: stay held
                    end else if (dly_cnt_r + 32'h1 >= dly_load) begin
                        st_r <= SCPS_ST_RUN;          // R2 R4
                    end else begin
                        dly_cnt_r <= dly_cnt_r + 32'h1;
                    end
                end
                SCPS_ST_RUN: st_r <= SCPS_ST_RUN;
                SCPS_ST_BAD: st_r <= SCPS_ST_BAD;
                default:     st_r <= SCPS_ST_HOLD;
            endcase
        end
    end
    assign core_ready = (st_r == SCPS_ST_RUN);

    // =====================================================
    // Divider control register
    // The fuse is sampled once, just after reset, so a strap that is
    // slow to settle during reset is still seen.
    // Limitation: a divider write in the first cycle after reset has
    // no effect, since the change enable is still clear then.
    // A rewrite of the enable alone inside the window is ignored.
    logic [3:0] div_sel_r;             // divider_select
    logic       pce_r;                 // prescaler_change_enable
    logic [2:0] pce_cnt_r;             // Cycles since enable
    logic       rst_seen_r;            // First cycle after reset done
    logic       wr_div;                // Write to divider control
    logic       lone_pce;              // Enable-only write

    assign wr_div   = reg_wr && (reg_addr == SCPS_OFS_DIVCTL);
    assign lone_pce = wr_div && (reg_wdata == (8'h1 << SCPS_PCE_BIT));  // R12

    // Change enable window and divider update
    // A new code wins over the window running out in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pce_r      <= 1'b0;
            pce_cnt_r  <= 3'h0;
            rst_seen_r <= 1'b0;
            div_sel_r  <= SCPS_DIV_RST1;
        end else begin
            rst_seen_r <= 1'b1;
            // Fuse is a strap: caught on the first clocked cycle
            if (!rst_seen_r) begin
                div_sel_r <= divide_by_eight_fuse ? SCPS_DIV_RST8 : SCPS_DIV_RST1; // R17
            end
            if (pce_r) begin
                if (wr_div && !reg_wdata[SCPS_PCE_BIT]) begin
                    div_sel_r <= reg_wdata[3:0];     // R18
                    pce_r     <= 1'b0;               // R14
                end else if (pce_cnt_r + 3'h1 >= SCPS_PCE_WIN) begin
                    pce_r <= 1'b0;                   // R14
                end else begin
                    pce_cnt_r <= pce_cnt_r + 3'h1;   // Rewrite does not extend
                end
            end else if (lone_pce) begin
                pce_r     <= 1'b1;                   // R12
                pce_cnt_r <= 3'h0;
            end
        end
    end

    // =====================================================
    // Trim register
    // Any value is accepted: software keeps the rate low enough
    // while the memories are written, since this oscillator also
    // times those writes.
    // Range and tune go straight to the analog trim, no staging.
    logic [7:0] trim_r;                // rc_oscillator_trim

    // Factory value at reset, software may retune
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            trim_r <= FACTORY_TRIM;                  // R19
        end else if (reg_wr && reg_addr == SCPS_OFS_TRIM) begin
            trim_r <= reg_wdata;
        end
    end
    // Analog oscillator reads range and tune directly
    assign trim_range_bit = trim_r[SCPS_RANGE_BIT];  // R20
    assign trim_tune_bits = trim_r[6:0];             // R21

    // =====================================================
    // Prescaler
    // Counter runs on the undivided clock; sys_clk_en qualifies domains
    // A new code waits for the end of the running period, so the
    // first period at the new rate starts at most one old period
    // after the write. No period is ever cut short: that is the
    // glitch that a mid-period switch would make.
    logic [7:0] pre_cnt_r;             // Period count
    logic [3:0] act_sel_r;             // Divider in force
    logic       en_r;                  // Divided clock enable
    logic       out_r;                 // Divided clock level
    logic [8:0] factor;                // Division factor
    logic       wrap;                  // Period boundary

    // Reserved codes fall back to /256 so the rate never rises
    assign factor = (act_sel_r > SCPS_DIV_MAX) ? 9'h100 : (9'h1 << act_sel_r); // R16
    assign wrap   = ({1'b0, pre_cnt_r} + 9'h1 >= factor);

    // Switch only on a period boundary: no short pulse can appear
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pre_cnt_r <= 8'h0;
            act_sel_r <= SCPS_DIV_RST1;
            en_r      <= 1'b0;
            out_r     <= 1'b0;
        end else begin
            en_r <= wrap;                                       // R9
            if (wrap) begin
                pre_cnt_r <= 8'h0;
                act_sel_r <= div_sel_r;                         // R10 R11
            end else begin
                pre_cnt_r <= pre_cnt_r + 8'h1;
            end
            // Output high for first half of each period
            out_r <= (factor == 9'h1) ? ~out_r : ({1'b0, pre_cnt_r} + 9'h1 < (factor >> 1)) || wrap;
        end
    end
    assign sys_clk_en = en_r;                                   // R9

    // Gap watch: cycles since the previous enable pulse. It stays at
    // zero until the first pulse, so the start after reset is not judged.
    logic [8:0] gap_r;                 // Cycles since last enable

    // Restart on every pulse, count up in between
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            gap_r <= 9'h0;
        end else if (en_r) begin
            gap_r <= 9'h1;             // Pulse seen: restart
        end else if (gap_r != 9'h0) begin
            gap_r <= gap_r + 9'h1;     // Inside a period
        end
    end

    // =====================================================
    // Clock output pin
    // Driven whenever the fuse is set, reset or not
    // At divide by one the pin toggles each cycle, so it shows half the
    // undivided rate; a flop cannot copy the clock itself.
    assign clock_output_pin    = out_r;                         // R7
    assign clock_output_pin_oe = clock_output_fuse;             // R6

    // =====================================================
    // Read port
    // Data stand for one cycle after the strobe and are zero
    // otherwise, so a stray sample never sees stale contents.
    // Unmapped offsets read as zero.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                SCPS_OFS_TRIM:   reg_rdata <= trim_r;
                SCPS_OFS_DIVCTL: reg_rdata <= {pce_r, 3'h0, div_sel_r};
                SCPS_OFS_STAT:   reg_rdata <= {6'h0, st_r};
                default:         reg_rdata <= 8'h0;
            endcase
        end else begin
            reg_rdata <= 8'h0;
        end
    end

    // =====================================================
    // Assertions
    // Properties watch design state and the input ports; most are quiet in reset.
    // Period checks stand on the gap watch in the prescaler section.

    // Window closes on time
    pce_timeout_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R14
        $rose(pce_r) |-> ##[1:4] !pce_r)
        else $error("change enable outlived window");

    // Enable only from a lone write
    pce_lone_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
        $rose(pce_r) |-> $past(lone_pce))
        else $error("change enable set without lone write");

    // No code lands outside the window
    div_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R13
        (wr_div && !pce_r && rst_seen_r) |=> $stable(div_sel_r))
        else $error("divider changed without enable");

    // Code lands when written in time
    div_write_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R18
        (pce_r && wr_div && !reg_wdata[SCPS_PCE_BIT]) |=> div_sel_r == $past(reg_wdata[3:0]))
        else $error("divider write lost");

    // Factory trim after reset
    trim_reset_a: assert property (@(posedge sys_clk) // R19
        !resetn |=> trim_r == FACTORY_TRIM)
        else $error("trim not factory after reset");

    // Pin driver follows the fuse
    clkout_oe_a: assert property (@(posedge sys_clk) // R6
        clock_output_pin_oe == clock_output_fuse)
        else $error("clock output enable wrong");

    // Divider swaps only at a boundary
    sel_switch_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R10
        !$stable(act_sel_r) |-> $past(wrap))
        else $error("divider switched mid period");

    // Divide by one pulses every cycle
    en_div1_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R16
        (act_sel_r == 4'h0 && $past(act_sel_r) == 4'h0 && $past(resetn)) |-> en_r)
        else $error("divide by one not every cycle");

    // Reserved start-up code never releases
    ready_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R2
        (startup_time_fuses == SCPS_SUT_RSVD && $stable(startup_time_fuses)) |=> !core_ready || $past(core_ready))
        else $error("released on reserved code");

    // Fuse picks the reset code
    div_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R17
        $rose(rst_seen_r) |-> div_sel_r == (divide_by_eight_fuse ? SCPS_DIV_RST8 : SCPS_DIV_RST1))
        else $error("divider reset code wrong");

    // Pending code taken at the boundary
    act_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R11
        wrap |=> act_sel_r == $past(div_sel_r))
        else $error("pending divider not taken");

    // One enable pulse per period
    en_wrap_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R9
        wrap |=> en_r)
        else $error("enable pulse missing");

    // Pin rises at each period start
    clkout_high_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R7
        (wrap && factor != 9'h1) |=> clock_output_pin)
        else $error("clock output not high at period start");

    // Written trim reaches the oscillator
    trim_write_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R20 R21
        (reg_wr && reg_addr == SCPS_OFS_TRIM) |=> {trim_range_bit, trim_tune_bits} == $past(reg_wdata))
        else $error("trim write not applied");

    // Read data stand one cycle only
    rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$past(reg_rd) |-> reg_rdata == 8'h0)
        else $error("read data outside read cycle");

    // Reserved start-up code parks the machine
    bad_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R2 R4
        st_r == SCPS_ST_BAD |=> st_r == SCPS_ST_BAD && !core_ready)
        else $error("left the reserved state");

    // Every period has the length in force
    gap_glitch_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R10 R16
        (en_r && gap_r != 9'h0) |-> gap_r == $past(factor))
        else $error("divided period has wrong length");

    // Rewrite keeps the window running
    pce_rewrite_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R14
        (pce_r && lone_pce) |=> !pce_r || pce_cnt_r != 3'h0)
        else $error("rewrite restarted the window");
endmodule

// *** sim/scps_ext_src.sv ***
`timescale 1ns/1ps
// ==================================================
// Far-side clock sources with steady periods
module scps_ext_src #(
    parameter int HALF_NS = 40    // External source half period
) (
    // Timer clock gate
    input  logic external_timer_clock_enable,
    // Source clocks
    output logic external_clock_input_pin,
    output logic lp_osc_clk,
    output logic rc_osc_clk,
    output logic timer_oscillator_input
);
    // Timer input stays quiet until software has enabled it
    initial begin
        timer_oscillator_input = 1'b0;
        wait (external_timer_clock_enable === 1'b1);
        forever #(HALF_NS * 4) timer_oscillator_input = ~timer_oscillator_input;
    end
    // External source never steps its period
    initial begin
        external_clock_input_pin = 1'b0;
        forever #(HALF_NS) external_clock_input_pin = ~external_clock_input_pin;
    end
    // Slow low-power oscillator, coarse period
    initial begin
        lp_osc_clk = 1'b0;
        forever #3906 lp_osc_clk = ~lp_osc_clk;
    end
    // Internal RC oscillator
    initial begin
        rc_osc_clk = 1'b0;
        forever #62 rc_osc_clk = ~rc_osc_clk;
    end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
// ==================================================
// Bench for clock select and prescaler
module tb_top;
    import scps_pkg::*;
    logic       sys_clk, resetn, co_f, d8_f, reg_wr, reg_rd, en, pin, oe, rdy, rng, lp, ex, xc, lc, rc;
    logic [3:0] src_f;     // Source fuses
    logic [1:0] sut_f;     // Start-up fuses
    logic [1:0] reg_addr;  // Register address
    logic [7:0] wd, rdata; // Write and read data
    logic [6:0] tune;      // Tune bits
    logic [15:0] seed;     // Random state
    int         failures, samples_checked;

    // ==================================================
    // Design and far side; delays shortened to keep the run brief
    scps_clock_ctrl #(.LP_SHORT_CK(10), .LP_LONG_CK(30), .EXT_SHORT_CK(16), .EXT_LONG_CK(40)) scps_clock_ctrl_i (
        .sys_clk(sys_clk), .resetn(resetn), .clock_source_select_fuses(src_f), .startup_time_fuses(sut_f),
        .clock_output_fuse(co_f), .divide_by_eight_fuse(d8_f), .lp_osc_clk(lc), .rc_osc_clk(rc),
        .external_clock_input_pin(xc), .reg_addr(reg_addr), .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .sys_clk_en(en), .clock_output_pin(pin), .clock_output_pin_oe(oe), .core_ready(rdy),
        .trim_tune_bits(tune), .trim_range_bit(rng), .src_is_lp(lp), .src_is_ext(ex));
    scps_ext_src scps_ext_src_i (.external_timer_clock_enable(1'b1), .external_clock_input_pin(xc),
        .lp_osc_clk(lc), .rc_osc_clk(rc), .timer_oscillator_input());

    // ==================================================
    // Helpers
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Reserved codes act as the slowest divide
    function automatic int per(input logic [3:0] c);
        return (c > 4'h8) ? 256 : (1 << c);
    endfunction
    function automatic int dly(input logic [3:0] s, input logic [1:0] t);
        if (t == 2'h0) return 14;
        if (s == SCPS_SRC_EXT) return (t == 2'h1) ? 30 : 54;
        return (t == 2'h1) ? 24 : 44;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Bus cycles, one strobe cycle each, a gap before the next
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; wd <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Cycles until a signal reaches a level, bounded
    task automatic wt(input bit p, input logic v, output int n);
        n = 0;
        do begin @(posedge sys_clk); #1 n++; end while ((p ? pin : en) !== v && n < 600);
    endtask
    // Reset with fuse set, then start-up and reset values
    task automatic rst(input logic [3:0] s, input logic [1:0] t, input logic d8, input logic co);
        int n;
        logic [7:0] d;
        @(posedge sys_clk);
        resetn <= 1'b0; src_f <= s; sut_f <= t; d8_f <= d8; co_f <= co;
        repeat (3) @(posedge sys_clk);
        chk("clk_out_oe", co, oe);
        resetn <= 1'b1;
        n = 0;
        while (rdy !== 1'b1 && n < 200) begin @(posedge sys_clk); #1 n++; end
        chk("src_lp", s == SCPS_SRC_LP128, lp);
        chk("src_ext", s == SCPS_SRC_EXT, ex);
        if (t == SCPS_SUT_RSVD) begin
            chk("ready_rsvd", 0, rdy);
            rd(SCPS_OFS_STAT, d);
            chk("status", 8'h03, d);
        end else begin
            chk("startup_ok", 1, n >= dly(s, t) - 1 && n <= dly(s, t) + 2);
            rd(SCPS_OFS_DIVCTL, d);
            chk("div_reset", d8 ? 8'h03 : 8'h00, d);
            rd(SCPS_OFS_TRIM, d);
            chk("trim_reset", 8'h80, d);
        end
    endtask
    // Timed divider change and rate after the switch
    task automatic chg(input logic [3:0] o, input logic [3:0] c);
        int p, q;
        logic [7:0] d;
        wr(SCPS_OFS_DIVCTL, 8'h80);
        wr(SCPS_OFS_DIVCTL, {4'h0, c});
        for (int i = 0; i < 4; i++) begin
            wt(0, 1'b1, p);
            wt(0, 1'b1, p);
            chk("no_glitch", 1, p >= (per(o) < per(c) ? per(o) : per(c)));
        end
        chk("en_period", 16'(per(c)), 16'(p));
        if (c != 4'h0) begin
            wt(1, 1'b0, p);
            wt(1, 1'b1, p);
            wt(1, 1'b0, p);
            wt(1, 1'b1, q);
            chk("pin_period", 16'(per(c)), 16'(p + q));
        end
        rd(SCPS_OFS_DIVCTL, d);
        chk("div_code", {4'h0, c}, d);
    endtask

    // ==================================================
    // Main sequence
    initial begin
        logic [7:0] d;
        logic [3:0] o, c;
        resetn = 1'b0; co_f = 1'b1; d8_f = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        src_f = SCPS_SRC_LP128; sut_f = 2'h0; reg_addr = 2'h0; wd = 8'h00; seed = 16'h0010;
        failures = 0; samples_checked = 0;
        for (int i = 0; i < 8; i++) rst(i[2] ? SCPS_SRC_EXT : SCPS_SRC_LP128, i[1:0], i[0], i[1]);
        rst(SCPS_SRC_EXT, 2'h0, 1'b1, 1'b1);
        // Random trim values, range and tune split
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(SCPS_OFS_TRIM, seed[7:0]);
            rd(SCPS_OFS_TRIM, d);
            chk("trim_rw", seed[7:0], d);
            chk("trim_split", seed[7:0], {rng, tune});
        end
        // Enable written with other bits set does not arm
        wr(SCPS_OFS_DIVCTL, 8'h81);
        wr(SCPS_OFS_DIVCTL, 8'h05);
        rd(SCPS_OFS_DIVCTL, d);
        chk("pce_refused", 8'h03, d);
        wr(SCPS_OFS_DIVCTL, 8'h80);
        rd(SCPS_OFS_DIVCTL, d);
        chk("pce_set", 8'h83, d);
        repeat (5) @(posedge sys_clk);
        rd(SCPS_OFS_DIVCTL, d);
        chk("pce_timeout", 8'h03, d);
        // Rewrite inside the window must not extend it
        wr(SCPS_OFS_DIVCTL, 8'h80);
        wr(SCPS_OFS_DIVCTL, 8'h80);
        @(posedge sys_clk);
        wr(SCPS_OFS_DIVCTL, 8'h05);
        rd(SCPS_OFS_DIVCTL, d);
        chk("no_extend", 8'h03, d);
        // Divider codes: ends, reserved, then random
        o = 4'h3;
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            c = (i == 0) ? 4'h0 : (i == 1) ? 4'h8 : (i == 2) ? 4'hc : 4'(seed % 9);
            chg(o, c);
            o = c;
        end
        rd(2'h3, d);
        chk("unmapped", 8'h00, d);
        rd(SCPS_OFS_STAT, d);
        chk("status_run", 8'h01, d);
        rst(SCPS_SRC_LP128, 2'h1, 1'b0, 1'b0);
        give_verdict();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end
endmodule
